//--- shared/pin_change_pkg.sv
// Constants for the pin change edge detector: register map, field widths,
// reset values and interrupt layout.
// Assumes a 32-bit APB bus with word-aligned registers.
package pin_change_pkg;
  localparam int PinCount = 16;
  localparam int AddrWidth = 8;
  localparam logic [7:0] RiseEnableAddr = 8'h00;
  localparam logic [7:0] FallEnableAddr = 8'h04;
  localparam logic [7:0] ChangeFlagAddr = 8'h08;
  localparam logic [7:0] ControlAddr = 8'h0C;
  localparam logic [7:0] IrqStatusAddr = 8'h10;
  localparam logic [7:0] IrqMaskAddr = 8'h14;
  localparam int MasterEnableBit = 0;
  localparam logic [15:0] EnableReset = 16'h0000;
  localparam logic [15:0] FlagReset = 16'h0000;
  localparam logic [15:0] PinReset = 16'h0000;
  localparam logic IrqReset = 1'h0;
  localparam logic MasterReset = 1'h0;
  localparam int IrqChangeBit = 0;
  localparam int IrqWidth = 1;
  localparam logic [31:0] ReadZero = 32'h0000_0000;
endpackage

//--- hdl/pin_change_edge_detector.sv
// Pin change edge detector: 16 monitored port pins, per-pin rising and
// falling enables, sticky change flags, APB register access, two interrupt outputs (irq, changeFlagIrq).
// Assumes pins and APB signals are synchronous to ref_clk.
// Notes for users of this block:
// - Every APB access takes one wait state. The first access cycle captures
//   read data into a flop, and the second cycle raises pready. That keeps
//   prdata registered and still valid at the completing edge.
// - Writes, flag clears and the status read-clear take effect only at the
//   completing edge. A clear and a detected edge in one cycle: the edge wins.
// - Changing an edge enable while the master enable is set may raise a
//   spurious change. Software clears the master enable first, or clears or
//   masks what follows.
// - A pin is seen two flops late. Its first compare after reset is made
//   against a low level.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module pin_change_edge_detector (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] monitoredPortPin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic changeFlagIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] pinSync1;
    logic [15:0] pinSync2;
    logic [15:0] pinPrev;
    logic primed;
    logic [15:0] risingEdgeChangeEnable;
    logic [15:0] fallingEdgeChangeEnable;
    logic [15:0] pinChangeFlags;
    logic changeDetectMasterEnable;
    logic irqStatus;
    logic irqMask;
    logic [31:0] rdata;
    logic ackPending;
  } state_t;

  state_t cur_q;
  state_t nxt_d;
  logic wrStb;
  logic rdStb;
  logic rdCap;
  logic known;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] hit;
  logic [15:0] wlo;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait state. The first access cycle captures read data,
  // and the second completes the transfer, where writes and side effects land.
  assign wrStb = psel & penable & pwrite & cur_q.ackPending;
  assign rdStb = psel & penable & ~pwrite & cur_q.ackPending;
  assign rdCap = psel & penable & ~pwrite & ~cur_q.ackPending;
  assign known = (paddr == pin_change_pkg::RiseEnableAddr)
    | (paddr == pin_change_pkg::FallEnableAddr)
    | (paddr == pin_change_pkg::ChangeFlagAddr)
    | (paddr == pin_change_pkg::ControlAddr)
    | (paddr == pin_change_pkg::IrqStatusAddr)
    | (paddr == pin_change_pkg::IrqMaskAddr);
  assign pready = psel & penable & cur_q.ackPending;
  assign pslverr = pready & ~known;
  assign prdata = cur_q.rdata;
  assign changeFlagIrq = |cur_q.pinChangeFlags;
  assign irq = cur_q.irqStatus & cur_q.irqMask;
  // Byte lanes applied to the low half-word
  assign wlo = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

  // Edge detection on the second sync stage against its previous sample
  assign rise = cur_q.pinSync2 & ~cur_q.pinPrev;
  assign fall = ~cur_q.pinSync2 & cur_q.pinPrev;
  assign hit = {16{cur_q.changeDetectMasterEnable & cur_q.primed}}
    & ((rise & cur_q.risingEdgeChangeEnable)
    | (fall & cur_q.fallingEdgeChangeEnable));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_d = cur_q;
    nxt_d.pinSync1 = monitoredPortPin;
    nxt_d.pinSync2 = cur_q.pinSync1;
    nxt_d.pinPrev = cur_q.pinSync2;
    nxt_d.primed = 1'b1;
    nxt_d.rdata = pin_change_pkg::ReadZero;
    // Wait-state marker: set after the first access cycle, cleared after the second
    nxt_d.ackPending = psel & penable & ~cur_q.ackPending;
    if (wrStb) begin
      case (paddr)
        pin_change_pkg::RiseEnableAddr: begin
          nxt_d.risingEdgeChangeEnable = wlo;
        end
        pin_change_pkg::FallEnableAddr: begin
          nxt_d.fallingEdgeChangeEnable = wlo;
        end
        pin_change_pkg::ChangeFlagAddr: begin
          // Writing zero clears a flag; ones leave it as is
          nxt_d.pinChangeFlags = cur_q.pinChangeFlags
            & (wlo | ~{{8{pstrb[1]}}, {8{pstrb[0]}}});
        end
        pin_change_pkg::ControlAddr: begin
          if (pstrb[0]) begin
            nxt_d.changeDetectMasterEnable = pwdata[pin_change_pkg::MasterEnableBit];
          end
        end
        pin_change_pkg::IrqMaskAddr: begin
          if (pstrb[0]) begin
            nxt_d.irqMask = pwdata[pin_change_pkg::IrqChangeBit];
          end
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in the wait cycle and stands in the completing one
    if (rdCap) begin
      case (paddr)
        pin_change_pkg::RiseEnableAddr: begin
          nxt_d.rdata[15:0] = cur_q.risingEdgeChangeEnable;
        end
        pin_change_pkg::FallEnableAddr: begin
          nxt_d.rdata[15:0] = cur_q.fallingEdgeChangeEnable;
        end
        pin_change_pkg::ChangeFlagAddr: begin
          nxt_d.rdata[15:0] = cur_q.pinChangeFlags;
        end
        pin_change_pkg::ControlAddr: begin
          nxt_d.rdata[pin_change_pkg::MasterEnableBit] = cur_q.changeDetectMasterEnable;
        end
        pin_change_pkg::IrqStatusAddr: begin
          // Include an event of this cycle, or the clear below would lose it
          nxt_d.rdata[pin_change_pkg::IrqChangeBit] = cur_q.irqStatus | (|hit);
        end
        pin_change_pkg::IrqMaskAddr: begin
          nxt_d.rdata[pin_change_pkg::IrqChangeBit] = cur_q.irqMask;
        end
        default: begin
        end
      endcase
    end
    // Read clears the status at the completing edge only
    if (rdStb && (paddr == pin_change_pkg::IrqStatusAddr)) begin
      nxt_d.irqStatus = 1'b0;
    end
    // Hardware set wins over any software clear in the same cycle
    nxt_d.pinChangeFlags = nxt_d.pinChangeFlags | hit;
    if (|hit) begin
      nxt_d.irqStatus = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; read data is captured in the access cycle and shown next
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_q.pinSync1 <= pin_change_pkg::PinReset;
      cur_q.pinSync2 <= pin_change_pkg::PinReset;
      cur_q.pinPrev <= pin_change_pkg::PinReset;
      cur_q.primed <= 1'b0;
      cur_q.risingEdgeChangeEnable <= pin_change_pkg::EnableReset;
      cur_q.fallingEdgeChangeEnable <= pin_change_pkg::EnableReset;
      cur_q.pinChangeFlags <= pin_change_pkg::FlagReset;
      cur_q.changeDetectMasterEnable <= pin_change_pkg::MasterReset;
      cur_q.irqStatus <= pin_change_pkg::IrqReset;
      cur_q.irqMask <= pin_change_pkg::IrqReset;
      cur_q.rdata <= pin_change_pkg::ReadZero;
      cur_q.ackPending <= 1'b0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rise_sets_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(rise & cur_q.risingEdgeChangeEnable) && cur_q.changeDetectMasterEnable && cur_q.primed)
    |=> (|cur_q.pinChangeFlags) && cur_q.irqStatus)
    else $error("enabled rising edge did not set flag");
  fall_sets_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(fall & cur_q.fallingEdgeChangeEnable) && cur_q.changeDetectMasterEnable && cur_q.primed)
    |=> (|cur_q.pinChangeFlags) && cur_q.irqStatus)
    else $error("enabled falling edge did not set flag");
  disabled_pin_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!wrStb && (cur_q.pinChangeFlags == 16'h0000)
     && ((cur_q.risingEdgeChangeEnable | cur_q.fallingEdgeChangeEnable) == 16'h0000))
    |=> cur_q.pinChangeFlags == 16'h0000)
    else $error("flag set on pin with no edge enabled");
  master_gates_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cur_q.changeDetectMasterEnable |=> $stable(cur_q.pinChangeFlags) || $past(wrStb))
    else $error("flag changed while master enable off");
  rise_reg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStb && paddr == pin_change_pkg::RiseEnableAddr && pstrb[1:0] == 2'h3)
    |=> cur_q.risingEdgeChangeEnable == $past(pwdata[15:0]))
    else $error("rising enable write lost");
  fall_reg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStb && paddr == pin_change_pkg::FallEnableAddr && pstrb[1:0] == 2'h3)
    |=> cur_q.fallingEdgeChangeEnable == $past(pwdata[15:0]))
    else $error("falling enable write lost");
  flag_no_sw_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |(cur_q.pinChangeFlags & ~$past(cur_q.pinChangeFlags) & ~$past(hit)) == 1'b0)
    else $error("flag set without detected edge");
  sync_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (monitoredPortPin[0] && !cur_q.pinSync1[0]) |=> ##1 rise[0] || !cur_q.primed)
    else $error("pin edge not seen two cycles later");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == (cur_q.irqStatus && cur_q.irqMask))
    else $error("interrupt output mismatch");

  // Bus handshake: one wait state, then completion
  ack_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && penable && !cur_q.ackPending) |-> !pready)
    else $error("pready raised without wait state");
  ack_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> cur_q.ackPending)
    else $error("access not completed after wait state");
  err_in_access_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error response outside access");
  read_idle_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(psel && penable) |=> prdata == pin_change_pkg::ReadZero)
    else $error("read data not idle outside access");
  read_upper_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pready && !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // Flag clearing, master gating and interrupt status
  flag_clear_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStb && paddr == pin_change_pkg::ChangeFlagAddr && pstrb[1:0] == 2'h3)
    |=> (cur_q.pinChangeFlags & ~$past(pwdata[15:0]) & ~$past(hit)) == 16'h0000)
    else $error("change flag not cleared by write");
  master_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStb && paddr == pin_change_pkg::ControlAddr && pstrb[0])
    |=> cur_q.changeDetectMasterEnable == $past(pwdata[pin_change_pkg::MasterEnableBit]))
    else $error("master enable write lost");
  hit_gated_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cur_q.changeDetectMasterEnable |-> hit == 16'h0000)
    else $error("edge detected while master enable off");
  pin_off_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cur_q.risingEdgeChangeEnable[0] && !cur_q.fallingEdgeChangeEnable[0]) |-> !hit[0])
    else $error("edge detected on disabled pin");
  status_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|hit) |=> cur_q.irqStatus)
    else $error("status not set by detected edge");
  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rdStb && paddr == pin_change_pkg::IrqStatusAddr && !(|hit)) |=> !cur_q.irqStatus)
    else $error("status not cleared by read");
  mask_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrStb && paddr == pin_change_pkg::IrqMaskAddr && pstrb[0])
    |=> cur_q.irqMask == $past(pwdata[pin_change_pkg::IrqChangeBit]))
    else $error("interrupt mask write lost");

endmodule // pin_change_edge_detector

//--- test/pin_driver.sv
// Board model for the sixteen monitored port pins.
// Assumes the bench asks for new levels just after a rising edge.
`timescale 1ns/1ps
module pin_driver (
  input wire logic ref_clk,
  input wire logic [15:0] want,
  output logic [15:0] pins
);
  // Pins settle one edge after the bench asks for them
  initial pins = 16'h0000;
  always @(posedge ref_clk) begin
    pins <= want;
  end
endmodule // pin_driver

//--- test/pin_change_edge_detector_tb_top.sv
// Self-checking bench for the pin change edge detector.
// Assumes an APB slave that may insert wait states; data taken at pready.
`timescale 1ns/1ps
module pin_change_edge_detector_tb_top;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdVal;
  logic [15:0] want = 16'h0000;
  logic [15:0] pins, riseEn, fallEn, modelFlags, prevPins;
  logic pready, pslverr, irq, flagIrq, errSeen;
  integer nErrors = 0;
  integer totalChecks = 0;
  integer seed = 99695;
  integer i;
  //////////////////////////////////////////////////////////////////////////
  // Clock, board model and design
  initial forever #20 clk = ~clk;
  pin_driver board (.ref_clk(clk), .want(want), .pins(pins));
  pin_change_edge_detector uut (.ref_clk(clk), .rst_n(rstN), .monitoredPortPin(pins),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .changeFlagIrq(flagIrq));
  //////////////////////////////////////////////////////////////////////////
  // Compare, bus cycle and pin step helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks = totalChecks + 1;
    if (got !== exp) begin
      nErrors = nErrors + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    errSeen = pslverr;
    rdVal = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chkFlags;
    apb(1'b0, pin_change_pkg::ChangeFlagAddr, 32'h0);
    chk(rdVal, {16'h0, modelFlags});
    chk({31'h0, flagIrq}, {31'h0, modelFlags != 16'h0});
  endtask
  task automatic pinStep(input logic [15:0] p, input logic on);
    if (on) modelFlags = modelFlags | (riseEn & ~prevPins & p) | (fallEn & prevPins & ~p);
    prevPins = p;
    want <= p;
    repeat (6) @(posedge clk);
  endtask
  task automatic completeRun;
    $display("checks=%0d errors=%0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    prevPins = 16'h0000;
    modelFlags = 16'h0000;
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    apb(1'b0, pin_change_pkg::RiseEnableAddr, 32'h0);
    chk(rdVal, 32'h0);
    apb(1'b0, pin_change_pkg::FallEnableAddr, 32'h0);
    chk(rdVal, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({errSeen, rdVal[30:0]}, 32'h8000_0000);
    $display("test reset and map done");
    for (i = 0; i < 5; i++) begin
      riseEn = (i == 0) ? 16'h0 : 16'($random(seed));
      fallEn = (i == 0) ? 16'h0 : 16'($random(seed));
      apb(1'b1, pin_change_pkg::ControlAddr, 32'h0);
      apb(1'b1, pin_change_pkg::RiseEnableAddr, {16'hFFFF, riseEn});
      apb(1'b1, pin_change_pkg::FallEnableAddr, {16'hFFFF, fallEn});
      apb(1'b0, pin_change_pkg::RiseEnableAddr, 32'h0);
      chk(rdVal, {16'h0, riseEn});
      apb(1'b0, pin_change_pkg::FallEnableAddr, 32'h0);
      chk(rdVal, {16'h0, fallEn});
      apb(1'b1, pin_change_pkg::ChangeFlagAddr, 32'h0);
      modelFlags = 16'h0000;
      apb(1'b1, pin_change_pkg::ControlAddr, 32'h1);
      repeat (5) begin
        pinStep(16'($random(seed)), 1'b1);
        chkFlags;
      end
      apb(1'b1, pin_change_pkg::ChangeFlagAddr, 32'hFFFF);
      chkFlags;
    end
    $display("test edges done");
    apb(1'b1, pin_change_pkg::ControlAddr, 32'h0);
    riseEn = 16'hFFFF;
    fallEn = 16'hFFFF;
    apb(1'b1, pin_change_pkg::RiseEnableAddr, 32'hFFFF);
    apb(1'b1, pin_change_pkg::FallEnableAddr, 32'hFFFF);
    apb(1'b1, pin_change_pkg::ChangeFlagAddr, 32'h0);
    modelFlags = 16'h0000;
    pinStep(~prevPins, 1'b0);
    chkFlags;
    apb(1'b1, pin_change_pkg::IrqMaskAddr, 32'h1);
    apb(1'b1, pin_change_pkg::ControlAddr, 32'h1);
    pinStep(~prevPins, 1'b1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, pin_change_pkg::IrqStatusAddr, 32'h0);
    chk(rdVal, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, pin_change_pkg::IrqMaskAddr, 32'h0);
    apb(1'b1, pin_change_pkg::ChangeFlagAddr, 32'h0);
    modelFlags = 16'h0000;
    pinStep(~prevPins, 1'b1);
    chk({31'h0, irq}, 32'h0);
    chkFlags;
    apb(1'b1, pin_change_pkg::IrqMaskAddr, 32'h1);
    chk({31'h0, irq}, 32'h1);
    $display("test master enable and interrupt done");
    completeRun;
  end
  // Watchdog cuts a hung run short
  initial begin
    repeat (20000) @(posedge clk);
    nErrors = nErrors + 1;
    completeRun;
  end
endmodule // pin_change_edge_detector_tb_top
